// [fce_defines.svh]
// shared constants for fault clear and enable control
`ifndef FCE_DEFINES_SVH
`define FCE_DEFINES_SVH

// ============================================================
// sizes
`define FCE_NUM_DIN 7
`define FCE_MODE_W 4
`define FCE_CODE_W 12

// ============================================================
// input function selections
`define FCE_MODE_CLEAR_FAULT 4'h1

// ============================================================
// fault report codes, hex digits of the displayed number
`define FCE_CODE_NONE 12'h000
`define FCE_CODE_STO 12'h602
`define FCE_CODE_BUS_LOST 12'h702
`define FCE_CODE_STOP_TMO 12'h703

// ============================================================
// control word bit positions (object 6040h)
`define FCE_CW_SWITCH_ON 0
`define FCE_CW_ENABLE_VOLT 1
`define FCE_CW_QUICK_STOP 2
`define FCE_CW_ENABLE_OP 3
`define FCE_CW_FAULT_RESET 7

// ============================================================
// stop timeout: default in microseconds, counted in cycles at 100 MHz
`define FCE_CLK_MHZ 100
`define FCE_STOP_TMO_US 1000
`define FCE_TMO_W 32
`define FCE_RESET_BIT 1'b0
`define FCE_COUNT_ZERO 32'h0000_0000

`endif

// [fce_pkg.sv]
// types for fault clear and enable control
`default_nettype none
package fce_pkg;
  `include "fce_defines.svh"
  typedef logic [`FCE_NUM_DIN-1:0] fce_din_t;
  typedef logic [`FCE_NUM_DIN*`FCE_MODE_W-1:0] fce_modes_t;
  typedef logic [`FCE_CODE_W-1:0] fce_code_t;
  typedef logic [15:0] fce_cw_t;
  typedef enum logic [1:0] {FCE_DISABLED, FCE_ENABLED, FCE_STOPPING} fce_state_e;
endpackage
`default_nettype wire

// [fce_fault_clear_enable.sv]
// fault latching, clearing and enable sequencing for the drive control
`timescale 1ns/100ps
`default_nettype none
`include "fce_defines.svh"

module fce_fault_clear_enable #(
  parameter logic [`FCE_TMO_W-1:0] STOP_TMO_CYC = `FCE_STOP_TMO_US * `FCE_CLK_MHZ
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic drive_enable_cmd_i,
  input wire logic drive_disable_cmd_i,
  input wire logic fault_clear_cmd_i,
  input wire fce_pkg::fce_cw_t ctrl_word_i,
  input wire logic ctrl_word_valid_i,
  input wire logic fieldbus_ctrl_i,
  input wire logic hw_enable_i,
  input wire fce_pkg::fce_din_t din_i,
  input wire fce_pkg::fce_modes_t input_function_select_i,
  input wire logic safe_torque_off_i,
  input wire logic bus_lost_i,
  input wire logic bus_lost_is_warning_i,
  input wire logic motor_stopped_i,
  output logic drive_enabled_o,
  output logic fault_o,
  output fce_pkg::fce_code_t fault_code_o,
  output logic warning_o,
  output fce_pkg::fce_code_t warning_code_o
);
  import fce_pkg::*;

  // ============================================================
  // input synchronisers
  // pins are asynchronous; two flops before anything looks at them
  fce_din_t din_meta_r;
  fce_din_t din_sync_r;
  fce_din_t din_prev_r;
  logic hwen_meta_r;
  logic hwen_sync_r;
  logic sto_meta_r;
  logic sto_sync_r;

  always_ff @(posedge mclk_i) begin
    din_meta_r <= din_i;
    din_sync_r <= din_meta_r;
    hwen_meta_r <= hw_enable_i;
    hwen_sync_r <= hwen_meta_r;
    sto_meta_r <= safe_torque_off_i;
    sto_sync_r <= sto_meta_r;
  end

  // previous synchronised level for edge detection
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      din_prev_r <= '0;
    end else begin
      din_prev_r <= din_sync_r;
    end
  end

  // ============================================================
  // clear sources
  function automatic fce_din_t clear_inputs(input fce_modes_t modes);
    fce_din_t sel;
    sel = '0;
    for (int i = 0; i < `FCE_NUM_DIN; i++) begin
      sel[i] = (modes[i*`FCE_MODE_W +: `FCE_MODE_W] == `FCE_MODE_CLEAR_FAULT);
    end
    return sel;
  endfunction

  // previous control word fault-reset bit, the reset acts on its rising edge
  logic cw_reset_prev_r;
  // previous control word enable pattern, the enable acts on its rising edge
  logic cw_en_prev_r;
  wire logic cw_reset_bit = ctrl_word_i[`FCE_CW_FAULT_RESET];
  wire fce_din_t din_rise = din_sync_r & ~din_prev_r;
  wire logic din_clear = |(din_rise & clear_inputs(input_function_select_i));
  wire logic cw_clear = fieldbus_ctrl_i & ctrl_word_valid_i & cw_reset_bit
    & ~cw_reset_prev_r;
  // command-type clears also disable; the input clear does not
  wire logic cmd_clear = fault_clear_cmd_i | cw_clear;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cw_reset_prev_r <= `FCE_RESET_BIT;
    end else if (ctrl_word_valid_i) begin
      cw_reset_prev_r <= cw_reset_bit;
    end
  end

  // ============================================================
  // enable and disable requests
  // control word enable needs switch on, voltage, quick stop released, op enable
  wire logic cw_enable = ctrl_word_i[`FCE_CW_SWITCH_ON] & ctrl_word_i[`FCE_CW_ENABLE_VOLT]
    & ctrl_word_i[`FCE_CW_QUICK_STOP] & ctrl_word_i[`FCE_CW_ENABLE_OP];
  wire logic cw_en_req = fieldbus_ctrl_i & ctrl_word_valid_i & cw_enable & ~cw_en_prev_r;
  wire logic cw_dis_req = fieldbus_ctrl_i & ctrl_word_valid_i & ~cw_enable;
  wire logic en_req = drive_enable_cmd_i | cw_en_req;
  wire logic dis_req = drive_disable_cmd_i | cw_dis_req;

  // ============================================================
  // fault latches; a new event wins over a clear in the same cycle
  logic sto_flt_r;
  logic bus_flt_r;
  logic tmo_flt_r;
  logic bus_warn_r;
  logic sw_enable_r;
  logic sw_enable_nxt;
  logic clear_armed_r;
  logic [`FCE_TMO_W-1:0] stop_cnt_r;
  fce_state_e state_r;
  fce_state_e state_nxt;

  wire logic any_clear = cmd_clear | (din_clear & clear_armed_r);
  wire logic bus_fault_ev = bus_lost_i & ~bus_lost_is_warning_i;
  wire logic stop_tmo_ev = (state_r == FCE_STOPPING) & ~motor_stopped_i
    & (stop_cnt_r >= STOP_TMO_CYC);
  wire logic fault_any = sto_flt_r | bus_flt_r | tmo_flt_r;
  // a still-active condition keeps its latch set, so the drive stays off
  wire logic cond_active = sto_sync_r | bus_fault_ev;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sto_flt_r <= `FCE_RESET_BIT;
      bus_flt_r <= `FCE_RESET_BIT;
      tmo_flt_r <= `FCE_RESET_BIT;
      bus_warn_r <= `FCE_RESET_BIT;
    end else begin
      sto_flt_r <= sto_sync_r | (sto_flt_r & ~any_clear);
      bus_flt_r <= bus_fault_ev | (bus_flt_r & ~any_clear);
      bus_warn_r <= bus_lost_i & bus_lost_is_warning_i;
      tmo_flt_r <= stop_tmo_ev | (tmo_flt_r & ~any_clear);
    end
  end

  // ============================================================
  // software enable request
  // a command clear drops the request; only a new enable restores it
  always_comb begin
    sw_enable_nxt = sw_enable_r;
    if (dis_req | cmd_clear) begin
      sw_enable_nxt = 1'b0;
    end else if (en_req) begin
      sw_enable_nxt = 1'b1;
    end
  end

  // the input clear is honoured only after a disable once the fault hit
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sw_enable_r <= `FCE_RESET_BIT;
      cw_en_prev_r <= `FCE_RESET_BIT;
      clear_armed_r <= `FCE_RESET_BIT;
    end else begin
      sw_enable_r <= sw_enable_nxt;
      if (ctrl_word_valid_i) begin
        cw_en_prev_r <= cw_enable;
      end
      if (!fault_any || any_clear) begin
        clear_armed_r <= 1'b0;
      end else if (dis_req && state_r != FCE_ENABLED) begin
        clear_armed_r <= 1'b1;
      end
    end
  end

  // ============================================================
  // drive state machine
  // enabling needs the hardware gate whatever clear method was used
  wire logic may_enable = sw_enable_nxt & hwen_sync_r & ~fault_any & ~cond_active;
  // an input clear leaves the software request standing, so may_enable brings the
  // drive back one cycle later, on the edge where fault_o falls; never both high

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FCE_DISABLED: begin
        if (may_enable) begin
          state_nxt = FCE_ENABLED;
        end
      end
      FCE_ENABLED: begin
        if (!hwen_sync_r || sto_sync_r) begin
          state_nxt = FCE_DISABLED;
        end else if (!sw_enable_nxt || fault_any || cond_active) begin
          state_nxt = FCE_STOPPING;
        end
      end
      FCE_STOPPING: begin
        if (motor_stopped_i || stop_tmo_ev || !hwen_sync_r) begin
          state_nxt = FCE_DISABLED;
        end
      end
      default: begin
        state_nxt = FCE_DISABLED;
      end
    endcase
  end

  // stop timer runs only while stopping
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_r <= FCE_DISABLED;
      stop_cnt_r <= `FCE_COUNT_ZERO;
    end else begin
      state_r <= state_nxt;
      if (state_r == FCE_STOPPING && state_nxt == FCE_STOPPING) begin
        stop_cnt_r <= stop_cnt_r + 1'b1;
      end else begin
        stop_cnt_r <= `FCE_COUNT_ZERO;
      end
    end
  end

  // ============================================================
  // registered outputs; lowest code wins when several faults stand
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      drive_enabled_o <= `FCE_RESET_BIT;
      fault_o <= `FCE_RESET_BIT;
      fault_code_o <= `FCE_CODE_NONE;
      warning_o <= `FCE_RESET_BIT;
      warning_code_o <= `FCE_CODE_NONE;
    end else begin
      drive_enabled_o <= (state_nxt == FCE_ENABLED);
      fault_o <= fault_any;
      if (sto_flt_r) begin
        fault_code_o <= `FCE_CODE_STO;
      end else if (bus_flt_r) begin
        fault_code_o <= `FCE_CODE_BUS_LOST;
      end else if (tmo_flt_r) begin
        fault_code_o <= `FCE_CODE_STOP_TMO;
      end else begin
        fault_code_o <= `FCE_CODE_NONE;
      end
      warning_o <= bus_warn_r;
      warning_code_o <= bus_warn_r ? `FCE_CODE_BUS_LOST : `FCE_CODE_NONE;
    end
  end
endmodule
`default_nettype wire

// [fce_fault_clear_enable_props.sv]
// assertions on the ports of the fault clear and enable block
`timescale 1ns/100ps
`default_nettype none
`include "fce_defines.svh"
module fce_fault_clear_enable_props (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic drive_enable_cmd_i,
  input wire logic drive_disable_cmd_i,
  input wire logic fault_clear_cmd_i,
  input wire logic hw_enable_i,
  input wire logic safe_torque_off_i,
  input wire logic bus_lost_i,
  input wire logic bus_lost_is_warning_i,
  input wire logic drive_enabled_o,
  input wire logic fault_o,
  input wire fce_pkg::fce_code_t fault_code_o,
  input wire logic warning_o,
  input wire fce_pkg::fce_code_t warning_code_o
);
  // ============================================================
  // checks, all in the one clock domain
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // a command followed by two samples with no enable, so a re-enable cannot mask it
  sequence s_clr; fault_clear_cmd_i ##1 !drive_enable_cmd_i [*2]; endsequence
  sequence s_dis; drive_disable_cmd_i ##1 !drive_enable_cmd_i [*2]; endsequence
  a_clr_disables: assert property (s_clr |-> !drive_enabled_o)
    else $error("drive enabled after clear command");
  a_dis_disables: assert property (s_dis |-> !drive_enabled_o)
    else $error("drive enabled after disable command");
  a_hw_gate_en: assert property (!hw_enable_i [*5] |-> !drive_enabled_o)
    else $error("drive enabled without hardware enable");
  a_fault_blocks_en: assert property (fault_o |-> !drive_enabled_o)
    else $error("drive enabled while fault latched");
  a_sto_code: assert property (safe_torque_off_i [*5] |-> fault_o && fault_code_o == `FCE_CODE_STO)
    else $error("safe torque off not reported");
  a_bus_fault: assert property ((bus_lost_i && !bus_lost_is_warning_i) [*3] |-> fault_o)
    else $error("bus loss not latched as fault");
  a_warn_code: assert property (warning_code_o == (warning_o ? `FCE_CODE_BUS_LOST : `FCE_CODE_NONE))
    else $error("warning code mismatch");
  a_code_match: assert property (fault_o == (fault_code_o != `FCE_CODE_NONE))
    else $error("fault flag and code disagree");
  a_code_known: assert property (fault_o |-> fault_code_o inside {12'h602, 12'h702, 12'h703})
    else $error("unexpected fault code");
endmodule
bind fce_fault_clear_enable fce_fault_clear_enable_props i_props (
  .mclk_i(mclk_i),
  .rst_i(rst_i),
  .drive_enable_cmd_i(drive_enable_cmd_i),
  .drive_disable_cmd_i(drive_disable_cmd_i),
  .fault_clear_cmd_i(fault_clear_cmd_i),
  .hw_enable_i(hw_enable_i),
  .safe_torque_off_i(safe_torque_off_i),
  .bus_lost_i(bus_lost_i),
  .bus_lost_is_warning_i(bus_lost_is_warning_i),
  .drive_enabled_o(drive_enabled_o),
  .fault_o(fault_o),
  .fault_code_o(fault_code_o),
  .warning_o(warning_o),
  .warning_code_o(warning_code_o)
);
`default_nettype wire

// [fce_ctrl_model.sv]
// behavioural machine controller: host commands, control word and clear input
`timescale 1ns/100ps
`default_nettype none
module fce_ctrl_model (
  input wire logic mclk_i,
  output logic drive_enable_cmd_o,
  output logic drive_disable_cmd_o,
  output logic fault_clear_cmd_o,
  output fce_pkg::fce_cw_t cw_o,
  output logic cw_valid_o,
  output fce_pkg::fce_din_t din_o
);
  import fce_pkg::*;
  logic [2:0] cmd;
  // ============================================================
  // command pulses, one bit each: 0 enable, 1 disable, 2 clear
  assign drive_enable_cmd_o = cmd[0];
  assign drive_disable_cmd_o = cmd[1];
  assign fault_clear_cmd_o = cmd[2];
  initial begin
    cmd = 3'h0;
    cw_o = 16'hffff;
    cw_valid_o = 1'b0;
    din_o = 7'h00;
  end
  task automatic pulse(input int k);
    @(posedge mclk_i) #1 cmd[k] = 1'b1;
    @(posedge mclk_i) #1 cmd = 3'h0;
  endtask
  // an idle word shows the inverse, since the block must not read it
  task automatic send_cw(input fce_cw_t w);
    @(posedge mclk_i) #1 cw_o = w;
    cw_valid_o = 1'b1;
    @(posedge mclk_i) #1 cw_valid_o = 1'b0;
    cw_o = ~w;
  endtask
  // held long enough to pass the synchronisers, then dropped
  task automatic din_pulse(input int idx);
    @(posedge mclk_i) #1 din_o[idx] = 1'b1;
    repeat (6) @(posedge mclk_i);
    #1 din_o = 7'h00;
  endtask
endmodule
`default_nettype wire

// [fce_fault_clear_enable_tb.sv]
// self-checking testbench for the fault clear and enable block
`timescale 1ns/100ps
`default_nettype none
module fce_fault_clear_enable_tb;
  import fce_pkg::*;
  logic mclk, rst, fb_ctrl, hw_en, safe_torque_off, bus_lost, bus_warn, stopped;
  logic en_cmd, dis_cmd, clr_cmd, cw_valid, drive_en, fault, warn;
  fce_cw_t cw;
  fce_din_t din;
  fce_code_t code, warn_code;
  fce_modes_t din_mode;
  int err_total = 0;
  int comparisons = 0;
  fce_ctrl_model i_ctl (.mclk_i(mclk), .drive_enable_cmd_o(en_cmd),
    .drive_disable_cmd_o(dis_cmd), .fault_clear_cmd_o(clr_cmd), .cw_o(cw),
    .cw_valid_o(cw_valid), .din_o(din));
  fce_fault_clear_enable #(.STOP_TMO_CYC(32'd20)) i_dut (.mclk_i(mclk), .rst_i(rst),
    .drive_enable_cmd_i(en_cmd), .drive_disable_cmd_i(dis_cmd), .fault_clear_cmd_i(clr_cmd),
    .ctrl_word_i(cw), .ctrl_word_valid_i(cw_valid), .fieldbus_ctrl_i(fb_ctrl),
    .hw_enable_i(hw_en), .din_i(din), .input_function_select_i(din_mode),
    .safe_torque_off_i(safe_torque_off), .bus_lost_i(bus_lost), .bus_lost_is_warning_i(bus_warn),
    .motor_stopped_i(stopped), .drive_enabled_o(drive_en), .fault_o(fault),
    .fault_code_o(code), .warning_o(warn), .warning_code_o(warn_code));
  // ============================================================
  // clock, helpers and verdict
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ============================================================
  // scenarios
  task automatic t_enable;
    hw_en = 1'b0;
    i_ctl.pulse(0);
    cyc(5);
    chk("en_hw_low", drive_en, 12'h0);
    hw_en = 1'b1;
    cyc(5);
    chk("en_hw_high", drive_en, 12'h1);
    $display("test enable done");
  endtask
  task automatic t_sto;
    safe_torque_off = 1'b1;
    cyc(5);
    chk("sto_code", code, 12'h602);
    chk("sto_en", drive_en, 12'h0);
    safe_torque_off = 1'b0;
    // let the released pin pass the synchroniser, or the still-high level refaults
    cyc(3);
    i_ctl.pulse(2);
    cyc(2);
    chk("clr_fault", fault, 12'h0);
    cyc(5);
    chk("clr_no_self_en", drive_en, 12'h0);
    i_ctl.pulse(0);
    cyc(3);
    chk("en_after_clr", drive_en, 12'h1);
    $display("test sto done");
  endtask
  task automatic t_cw;
    fb_ctrl = 1'b1;
    bus_warn = 1'b1;
    bus_lost = 1'b1;
    cyc(4);
    chk("warn_code", warn_code, 12'h702);
    chk("warn_flag", warn, 12'h1);
    chk("warn_no_fault", fault, 12'h0);
    bus_warn = 1'b0;
    cyc(4);
    chk("bus_code", code, 12'h702);
    chk("warn_off", warn, 12'h0);
    bus_lost = 1'b0;
    i_ctl.send_cw(16'h0086);
    cyc(2);
    chk("cw_clr", fault, 12'h0);
    chk("cw_clr_dis", drive_en, 12'h0);
    i_ctl.send_cw(16'h000f);
    cyc(3);
    chk("cw_en", drive_en, 12'h1);
    i_ctl.send_cw(16'h0007);
    cyc(3);
    chk("cw_dis", drive_en, 12'h0);
    fb_ctrl = 1'b0;
    $display("test control word done");
  endtask
  task automatic t_tmo;
    i_ctl.pulse(0);
    stopped = 1'b0;
    i_ctl.pulse(1);
    cyc(30);
    chk("tmo_code", code, 12'h703);
    stopped = 1'b1;
    i_ctl.pulse(2);
    cyc(3);
    chk("tmo_clr", fault, 12'h0);
    $display("test stop timeout done");
  endtask
  task automatic t_din;
    i_ctl.pulse(0);
    cyc(3);
    bus_lost = 1'b1;
    cyc(3);
    bus_lost = 1'b0;
    i_ctl.din_pulse(2);
    cyc(3);
    chk("din_unarmed", fault, 12'h1);
    i_ctl.pulse(1);
    i_ctl.pulse(0);
    i_ctl.din_pulse(2);
    chk("din_clr", fault, 12'h0);
    chk("din_en", drive_en, 12'h1);
    // second round: the enable pin is only connected after the clear toggled
    bus_lost = 1'b1;
    cyc(3);
    bus_lost = 1'b0;
    hw_en = 1'b0;
    i_ctl.pulse(1);
    i_ctl.pulse(0);
    i_ctl.din_pulse(2);
    chk("din_clr_gated", fault, 12'h0);
    chk("din_hw_gate", drive_en, 12'h0);
    hw_en = 1'b1;
    cyc(4);
    chk("din_en_late", drive_en, 12'h1);
    $display("test input clear done");
  endtask
  initial begin
    rst = 1'b1;
    {fb_ctrl, hw_en, safe_torque_off, bus_lost, bus_warn} = 5'h00;
    stopped = 1'b1;
    din_mode = 28'h030_0100;
    cyc(2);
    rst = 1'b0;
    cyc(3);
    chk("rst_en", drive_en, 12'h0);
    t_enable();
    t_sto();
    t_cw();
    t_tmo();
    t_din();
    final_report();
  end
  initial begin
    #20000;
    err_total++;
    final_report();
  end
endmodule
`default_nettype wire
